// [hdl/dads_defs.svh]
// Constants for the decimal adjust and decrement-skip execution block
`ifndef DADS_DEFS_SVH
`define DADS_DEFS_SVH
`define DADS_NIBBLE_MAX 4'h9
`define DADS_BCD_FIX 4'h6
`define DADS_DEST_WORKING 1'b0
`define DADS_DEST_FILE 1'b1
`define DADS_SKIP_CYCLES 2
`endif

// [hdl/dads_pkg.sv]
// Types for the decimal adjust and decrement-skip execution block
package dads_pkg;
  typedef enum logic [1:0] {
    DADS_OP_NONE = 2'b00,
    DADS_OP_ADJUST = 2'b01,
    DADS_OP_DECSKIP = 2'b10
  } dads_op_t;
  // Operation request from decode
  typedef struct packed {
    logic valid;
    dads_op_t op;
    logic dest;
    logic [6:0] addr;
    logic [7:0] fileData;
  } dads_req_t;
  // Result write-back toward the register file and working register
  typedef struct packed {
    logic workWe;
    logic [7:0] workData;
    logic fileWe;
    logic [6:0] fileAddr;
    logic [7:0] fileData;
    logic carryWe;
    logic carry;
  } dads_wb_t;
  typedef enum logic [0:0] {
    DADS_ST_RUN = 1'b0,
    DADS_ST_SKIP = 1'b1
  } dads_state_t;
endpackage

// [hdl/dads_bcd_adjust.sv]
// Packed decimal correction of an 8-bit binary sum
`timescale 1ns/100ps
`include "dads_defs.svh"
module dads_bcd_adjust
  import dads_pkg::*;
(
  // Operand and flags from the preceding addition
  input wire logic [7:0] sum,
  input wire logic halfCarry,
  input wire logic carryIn,
  // Corrected value
  output logic [7:0] adjusted,
  output logic carryOut
);
  logic [4:0] low;
  logic fixLow;
  logic [4:0] high;
  logic fixHigh;
  // =====================================
  // Nibble correction
  always_comb begin
    fixLow = halfCarry || (sum[3:0] > `DADS_NIBBLE_MAX);
    low = {1'b0, sum[3:0]} + (fixLow ? {1'b0, `DADS_BCD_FIX} : 5'h00);
    // Low nibble correction can ripple into the high nibble
    high = {1'b0, sum[7:4]} + {4'h0, low[4]};
    fixHigh = carryIn || (high > {1'b0, `DADS_NIBBLE_MAX});
    high = high + (fixHigh ? {1'b0, `DADS_BCD_FIX} : 5'h00);
    adjusted = {high[3:0], low[3:0]};
    carryOut = fixHigh || high[4];
  end
endmodule

// [hdl/dads_exec.sv]
// Execution stage for decimal adjust and decrement-skip-if-zero
`timescale 1ns/100ps
`include "dads_defs.svh"
// Overview of operation
// - Decimal adjust turns the working register sum into packed decimal, writes it back.
// - Decrement-skip subtracts one; destination bit picks working or file register.
// - Zero result discards the fetched next instruction, executing a no-operation.
// - Decrement-skip takes one cycle, or two cycles when skipping.
module dads_exec
  import dads_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Request from decode
  input wire dads_req_t req,
  // Working register and flags from the core
  input wire logic [7:0] workingRegister,
  input wire logic halfCarry,
  input wire logic carry,
  // Write-back
  output dads_wb_t wb,
  // Fetch stage control
  output logic squashFetched,
  output logic busy
);
  typedef struct packed {
    dads_state_t state;
    dads_wb_t wb;
    logic squash;
    logic busy;
  } dads_exec_state_t;

  dads_exec_state_t r;
  dads_exec_state_t next_r;
  logic [7:0] adjusted;
  logic adjCarry;
  logic [7:0] decremented;

  // =====================================
  // Decimal correction datapath
  dads_bcd_adjust u_adjust (
    .sum(workingRegister),
    .halfCarry(halfCarry),
    .carryIn(carry),
    .adjusted(adjusted),
    .carryOut(adjCarry)
  );

  assign decremented = req.fileData - 8'h01;

  // =====================================
  // Next-state logic; skip slot inserts a no-operation
  always_comb begin
    next_r = r;
    next_r.wb = '0;
    next_r.squash = 1'b0;
    next_r.busy = 1'b0;
    unique case (r.state)
      DADS_ST_RUN: begin
        if (req.valid && req.op == DADS_OP_ADJUST) begin
          next_r.wb.workWe = 1'b1;
          next_r.wb.workData = adjusted;
          next_r.wb.carryWe = 1'b1;
          next_r.wb.carry = adjCarry;
        end else if (req.valid && req.op == DADS_OP_DECSKIP) begin
          if (req.dest == `DADS_DEST_WORKING) begin
            next_r.wb.workWe = 1'b1;
            next_r.wb.workData = decremented;
          end else begin
            next_r.wb.fileWe = 1'b1;
            next_r.wb.fileAddr = req.addr;
            next_r.wb.fileData = decremented;
          end
          if (decremented == 8'h00) begin
            next_r.squash = 1'b1;
            next_r.busy = 1'b1;
            next_r.state = DADS_ST_SKIP;
          end
        end
      end
      DADS_ST_SKIP: begin
        // Second cycle executes the no-operation; requests are ignored
        next_r.state = DADS_ST_RUN;
      end
    endcase
  end

  // =====================================
  // State register
  always_ff @(posedge clk) begin
    if (srst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign wb = r.wb;
  assign squashFetched = r.squash;
  assign busy = r.busy;

  // =====================================
  // Checks
  property p_skip_two_cycles;
    @(posedge clk) disable iff (srst)
    (r.state == DADS_ST_RUN && req.valid && req.op == DADS_OP_DECSKIP && req.fileData == 8'h01)
      |=> squashFetched && busy ##1 !busy && !wb.workWe && !wb.fileWe;
  endproperty
  a_skip_two_cycles: assert property (p_skip_two_cycles) else $error("skip not two cycles");

  property p_zero_squash;
    @(posedge clk) disable iff (srst)
    (r.state == DADS_ST_RUN && req.valid && req.op == DADS_OP_DECSKIP && req.fileData == 8'h01) |=> squashFetched;
  endproperty
  a_zero_squash: assert property (p_zero_squash) else $error("zero result did not squash");

  property p_no_skip;
    @(posedge clk) disable iff (srst)
    (r.state == DADS_ST_RUN && req.valid && req.op == DADS_OP_DECSKIP && req.fileData != 8'h01)
      |=> !squashFetched && !busy;
  endproperty
  a_no_skip: assert property (p_no_skip) else $error("skip without zero");

  property p_dest_file;
    @(posedge clk) disable iff (srst)
    (r.state == DADS_ST_RUN && req.valid && req.op == DADS_OP_DECSKIP && req.dest)
      |=> wb.fileWe && !wb.workWe && wb.fileData == $past(req.fileData) - 8'h01;
  endproperty
  a_dest_file: assert property (p_dest_file) else $error("file destination wrong");

  property p_dest_work;
    @(posedge clk) disable iff (srst)
    (r.state == DADS_ST_RUN && req.valid && req.op == DADS_OP_DECSKIP && !req.dest)
      |=> wb.workWe && !wb.fileWe && wb.workData == $past(req.fileData) - 8'h01;
  endproperty
  a_dest_work: assert property (p_dest_work) else $error("working destination wrong");

  property p_adjust_write;
    @(posedge clk) disable iff (srst)
    (r.state == DADS_ST_RUN && req.valid && req.op == DADS_OP_ADJUST)
      |=> wb.workWe && wb.carryWe && !squashFetched;
  endproperty
  a_adjust_write: assert property (p_adjust_write) else $error("adjust did not write back");

  property p_adjust_digits;
    @(posedge clk) disable iff (srst)
    (wb.workWe && wb.carryWe) |-> wb.workData[3:0] <= 4'h9 && wb.workData[7:4] <= 4'h9;
  endproperty
  a_adjust_digits: assert property (p_adjust_digits) else $error("adjust result not decimal");

  property p_adjust_carry;
    @(posedge clk) disable iff (srst)
    (r.state == DADS_ST_RUN && req.valid && req.op == DADS_OP_ADJUST && carry) |=> wb.carry;
  endproperty
  a_adjust_carry: assert property (p_adjust_carry) else $error("carry lost in adjust");

  // =====================================
  // Reset and idle behaviour
  // Checked without a disable so that the reset itself is covered
  property p_reset_quiet;
    @(posedge clk)
    srst |=> wb == '0 && !squashFetched && !busy;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs not cleared by reset");

  // No operation or no request must never write anything back
  property p_idle_quiet;
    @(posedge clk) disable iff (srst)
    (r.state == DADS_ST_RUN && !(req.valid && req.op != DADS_OP_NONE))
      |=> wb == '0 && !squashFetched && !busy;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("write-back without a request");

  // =====================================
  // Skip slot behaviour
  // A request held into the no-operation slot is dropped, not deferred
  property p_skip_refuses;
    @(posedge clk) disable iff (srst)
    r.state == DADS_ST_SKIP |=> wb == '0 && !squashFetched && !busy;
  endproperty
  a_skip_refuses: assert property (p_skip_refuses) else $error("request taken in skip slot");

  // Fetch must see the discard and the stall together
  property p_busy_with_squash;
    @(posedge clk) disable iff (srst)
    busy |-> squashFetched;
  endproperty
  a_busy_with_squash: assert property (p_busy_with_squash) else $error("stall without discard");

  // Slots beyond the instruction's own cycle; the machine serves only one
  localparam int NopSlots = `DADS_SKIP_CYCLES - 1;
  property p_skip_slot_len;
    @(posedge clk) disable iff (srst)
    $rose(busy) |-> ##NopSlots !busy;
  endproperty
  a_skip_slot_len: assert property (p_skip_slot_len) else $error("skip slot length wrong");

  // =====================================
  // Write-back consistency
  // One destination per instruction; the register file port is single
  property p_single_target;
    @(posedge clk) disable iff (srst)
    !(wb.workWe && wb.fileWe);
  endproperty
  a_single_target: assert property (p_single_target) else $error("two destinations written");

  // A sum already in packed decimal with no carries must pass unchanged
  property p_adjust_identity;
    @(posedge clk) disable iff (srst)
    (r.state == DADS_ST_RUN && req.valid && req.op == DADS_OP_ADJUST && !carry && !halfCarry
      && workingRegister[3:0] <= 4'h9 && workingRegister[7:4] <= 4'h9)
      |=> wb.workData == $past(workingRegister) && !wb.carry;
  endproperty
  a_adjust_identity: assert property (p_adjust_identity) else $error("decimal value altered");
endmodule

// [test/tb.sv]
// Self-checking bench for the decimal adjust and decrement-skip block
`timescale 1ns/100ps
module tb;
  import dads_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  dads_req_t req = '0;
  logic [7:0] workingRegister = 8'h00;
  logic halfCarry = 1'b0;
  logic carry = 1'b0;
  dads_wb_t wb;
  logic squashFetched;
  logic busy;
  int miscompares = 0;
  int checksDone = 0;
  int cycles = 0;
  dads_exec uut (.clk(clk), .srst(srst), .req(req), .workingRegister(workingRegister),
    .halfCarry(halfCarry), .carry(carry), .wb(wb), .squashFetched(squashFetched), .busy(busy));
  // ==========================
  // Clock and hang guard
  initial begin
    forever #4 clk = ~clk;
  end
  // Ceiling far above the few dozen cycles the tests need
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      miscompares++;
      conclude();
    end
  end
  // ==========================
  // Comparison and verdict
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task conclude;
    $display("checks %0d, mismatches %0d", checksDone, miscompares);
    if (miscompares == 0 && checksDone > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Request stays valid afterwards, so it executes again at the next edge unless the caller clears it
  task issue(input dads_op_t op, input logic d, input logic [7:0] f, w, input logic hc, c);
    @(posedge clk);
    req <= '{1'b1, op, d, 7'h05, f};
    workingRegister <= w;
    halfCarry <= hc;
    carry <= c;
    @(posedge clk);
    #1;
  endtask
  // ==========================
  // Scenarios
  task adjust_case(input logic [7:0] w, input logic hc, c);
    logic [8:0] v;
    logic hi;
    v = {1'b0, w};
    hi = 1'b0;
    if (w[3:0] > 4'h9 || hc) v = v + 9'h006;
    if (v[7:4] > 4'h9 || c) begin
      v = v + 9'h060;
      hi = 1'b1;
    end
    issue(DADS_OP_ADJUST, 1'b0, 8'h00, w, hc, c);
    chk({wb.workWe, wb.workData, wb.carryWe, wb.carry, wb.fileWe}, {1'b1, v[7:0], 1'b1, hi | v[8], 1'b0});
  endtask
  // Held request lands in the cycle after: refused when skipping, taken otherwise
  task decskip_case(input logic d, input logic [7:0] f);
    logic [7:0] r;
    logic z;
    r = f - 8'h01;
    z = (r == 8'h00);
    issue(DADS_OP_DECSKIP, d, f, 8'h33, 1'b0, 1'b0);
    chk({wb.workWe, wb.fileWe, wb.carryWe}, {~d, d, 1'b0});
    chk(d ? {wb.fileAddr, wb.fileData} : {7'h00, wb.workData}, d ? {7'h05, r} : {7'h00, r});
    chk({squashFetched, busy}, {z, z});
    @(posedge clk);
    req.valid <= 1'b0;
    #1;
    chk({wb.workWe | wb.fileWe, squashFetched, busy}, {~z, 2'b00});
  endtask
  // A request with no operation must leave every output quiet
  task idle_case;
    issue(DADS_OP_NONE, 1'b1, 8'h01, 8'h9a, 1'b1, 1'b1);
    chk({wb, squashFetched, busy}, '0);
  endtask
  // ==========================
  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    #1;
    chk({wb, squashFetched, busy}, '0);
    adjust_case(8'h4d, 1'b0, 1'b0);
    adjust_case(8'h43, 1'b1, 1'b0);
    adjust_case(8'h9a, 1'b0, 1'b0);
    adjust_case(8'h12, 1'b0, 1'b1);
    adjust_case(8'h32, 1'b1, 1'b1);
    decskip_case(1'b1, 8'h01);
    decskip_case(1'b0, 8'h05);
    decskip_case(1'b0, 8'h01);
    decskip_case(1'b1, 8'h00);
    idle_case();
    adjust_case(8'h28, 1'b0, 1'b0);
    conclude();
  end
endmodule
